//--- hw/bpp_ctrl.v
// Battery pack protection control: power modes, FET enables, fault recovery
`timescale 1ns/1ps
`include "bpp_defines.vh"

module bpp_ctrl (
  // Clock and reset
  input wire clock_i,
  input wire sys_rst_i,
  // Comparator outputs
  input wire charger_sense_pin_i,
  input wire pack_negative_sense_pin_i,
  input wire cell_ov_i,
  input wire cell_ov_rel_i,
  input wire cell_uv_i,
  input wire cell_uv_hyst_i,
  input wire ocd_i,
  input wire scd_i,
  input wire scc_i,
  input wire hw_fault_i,
  // Nonvolatile configuration
  input wire [`BPP_DLY_W-1:0] ov_delay_i,
  input wire [`BPP_DLY_W-1:0] uv_delay_i,
  input wire [`BPP_DLY_W-1:0] ocd_delay_i,
  input wire [`BPP_DLY_W-1:0] scd_delay_i,
  input wire [`BPP_DLY_W-1:0] scc_delay_i,
  input wire ocd_range_high_i,
  input wire [3:0] ocd_code_i,
  input wire short_overcurrent_recovery_select_i,
  input wire uv_recovery_select_i,
  input wire undervoltage_shutdown_enable_i,
  // Outputs
  output reg charge_fet_enable_o,
  output reg discharge_fet_enable_o,
  output reg regulator_enable_o,
  output reg shutdown_o,
  output reg charger_present_o,
  output reg load_removed_o,
  output reg [8:0] ocd_threshold_mv_o,
  output reg [`BPP_NF-1:0] fault_latched_o
);

  // ****************************************
  // Power mode state machine codes
  // ****************************************
  localparam ST_ACTIVE = 2'b01;
  localparam ST_SHDN = 2'b10;

  // Full-width constants, cut on purpose to the counter widths
  localparam [31:0] TICK_LAST_W = `BPP_TICK_CYC - 1;
  localparam [31:0] UV_SHDN_W = `BPP_UV_SHDN_CYC;
  localparam [`BPP_DLY_W-1:0] TICK_LAST = TICK_LAST_W[`BPP_DLY_W-1:0];
  localparam [27:0] UV_SHDN_CYC = UV_SHDN_W[27:0];

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [`BPP_DLY_W-1:0] tick_cnt_reg;
  reg tick_reg;
  reg [27:0] uv_cnt_reg;
  wire [`BPP_NF-1:0] qual;
  wire [`BPP_NF-1:0] cond;
  wire [`BPP_DLY_W-1:0] delays [0:`BPP_NF-1];
  wire active;
  wire uv_long;
  reg [`BPP_NF-1:0] fault_next;
  wire [31:0] thr_hi_full;
  wire [31:0] thr_lo_full;

  assign active = state_reg[0];

  // ****************************************
  // Tick divider for delay counters
  // ****************************************
  // Coarse tick keeps counters narrow; resolution is one tick
  always @(posedge clock_i) begin
    if (sys_rst_i || !active) begin
      tick_cnt_reg <= {`BPP_DLY_W{1'b0}};
      tick_reg <= 1'b0;
    end else if (tick_cnt_reg == TICK_LAST) begin
      tick_cnt_reg <= {`BPP_DLY_W{1'b0}};
      tick_reg <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + {{(`BPP_DLY_W-1){1'b0}}, 1'b1};
      tick_reg <= 1'b0;
    end
  end

  // ****************************************
  // Fault persistence qualifiers
  // ****************************************
  // Monitoring is gated off in shutdown, live in every active state
  assign cond[`BPP_F_OV] = active & cell_ov_i;
  assign cond[`BPP_F_UV] = active & cell_uv_i;
  assign cond[`BPP_F_OCD] = active & ocd_i;
  assign cond[`BPP_F_SCD] = active & scd_i;
  assign cond[`BPP_F_SCC] = active & scc_i;
  assign delays[`BPP_F_OV] = ov_delay_i;
  assign delays[`BPP_F_UV] = uv_delay_i;
  assign delays[`BPP_F_OCD] = ocd_delay_i;
  assign delays[`BPP_F_SCD] = scd_delay_i;
  assign delays[`BPP_F_SCC] = scc_delay_i;

  genvar gi;
  generate
    for (gi = 0; gi < `BPP_NF; gi = gi + 1) begin : g_persist
      bpp_persist u_persist (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .tick_i(tick_reg),
        .delay_i(delays[gi]),
        .cond_i(cond[gi]),
        .qualified_o(qual[gi])
      );
    end
  endgenerate

  // ****************************************
  // Fault latches and recovery
  // ****************************************
  // A fresh trip wins over a recovery in the same cycle
  always @* begin
    fault_next = fault_latched_o;
    if (!cell_ov_rel_i) begin
      fault_next[`BPP_F_OV] = 1'b0;
    end
    if (!cell_uv_hyst_i && (!uv_recovery_select_i || load_removed_o)) begin
      fault_next[`BPP_F_UV] = 1'b0;
    end
    if (load_removed_o && (!short_overcurrent_recovery_select_i || charger_present_o)) begin
      fault_next[`BPP_F_OCD] = 1'b0;
      fault_next[`BPP_F_SCD] = 1'b0;
    end
    if (!charger_present_o) begin
      fault_next[`BPP_F_SCC] = 1'b0;
    end
    fault_next = fault_next | qual;
  end

  always @(posedge clock_i) begin
    if (sys_rst_i || state_reg == ST_SHDN) begin
      fault_latched_o <= {`BPP_NF{1'b0}};
    end else begin
      fault_latched_o <= fault_next;
    end
  end

  // ****************************************
  // Charger and load-removal detection
  // ****************************************
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      charger_present_o <= 1'b0;
      load_removed_o <= 1'b0;
    end else begin
      charger_present_o <= charger_sense_pin_i;
      load_removed_o <= !discharge_fet_enable_o && pack_negative_sense_pin_i;
    end
  end

  // ****************************************
  // Undervoltage shutdown timer
  // ****************************************
  // Counts cycles with any cell below UV plus hysteresis
  assign uv_long = (uv_cnt_reg >= UV_SHDN_CYC);

  always @(posedge clock_i) begin
    if (sys_rst_i || !active || !cell_uv_hyst_i || !undervoltage_shutdown_enable_i) begin
      uv_cnt_reg <= 28'h0000000;
    end else if (!uv_long) begin
      uv_cnt_reg <= uv_cnt_reg + 28'h0000001;
    end
  end

  // ****************************************
  // Power mode state machine
  // ****************************************
  always @* begin
    case (state_reg)
      ST_ACTIVE: begin
        if (uv_long) begin
          state_next = ST_SHDN;
        end else begin
          state_next = ST_ACTIVE;
        end
      end
      ST_SHDN: begin
        if (charger_sense_pin_i) begin
          state_next = ST_ACTIVE;
        end else begin
          state_next = ST_SHDN;
        end
      end
      default: state_next = ST_ACTIVE;
    endcase
  end

  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      state_reg <= ST_ACTIVE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // FET and regulator outputs
  // ****************************************
  // Registered drivers; hardware faults force both FETs off
  // OV blocks only charge and UV only discharge, so the pack can leave the limit
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      charge_fet_enable_o <= 1'b0;
      discharge_fet_enable_o <= 1'b0;
      regulator_enable_o <= 1'b0;
      shutdown_o <= 1'b0;
    end else begin
      regulator_enable_o <= (state_next == ST_ACTIVE);
      shutdown_o <= (state_next == ST_SHDN);
      charge_fet_enable_o <= (state_next == ST_ACTIVE) && !hw_fault_i &&
        !(fault_next[`BPP_F_OV] | fault_next[`BPP_F_OCD] | fault_next[`BPP_F_SCD] |
          fault_next[`BPP_F_SCC]);
      discharge_fet_enable_o <= (state_next == ST_ACTIVE) && !hw_fault_i &&
        !(fault_next[`BPP_F_UV] | fault_next[`BPP_F_OCD] | fault_next[`BPP_F_SCD] |
          fault_next[`BPP_F_SCC]);
    end
  end

  // ****************************************
  // Overcurrent threshold decode
  // ****************************************
  // Sums kept at full width, then cut; a four-bit code cannot pass either range top
  assign thr_hi_full = `BPP_OCD_HI_MIN_MV + `BPP_OCD_HI_STEP_MV * ocd_code_i;
  assign thr_lo_full = `BPP_OCD_LO_MIN_MV + `BPP_OCD_LO_STEP_MV * ocd_code_i;

  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      ocd_threshold_mv_o <= 9'h019;
    end else if (ocd_range_high_i) begin
      ocd_threshold_mv_o <= thr_hi_full[8:0];
    end else begin
      ocd_threshold_mv_o <= thr_lo_full[8:0];
    end
  end

endmodule

//--- hw/bpp_persist.v
// Persistence qualifier: condition must hold for a delay before acting
`timescale 1ns/1ps
`include "bpp_defines.vh"

module bpp_persist (
  // Clock and reset
  input wire clock_i,
  input wire sys_rst_i,
  // Timing
  input wire tick_i,
  input wire [`BPP_DLY_W-1:0] delay_i,
  // Condition and result
  input wire cond_i,
  output reg qualified_o
);

  reg [`BPP_DLY_W-1:0] count_reg;

  // Count ticks while condition holds; restart on any gap
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      count_reg <= {`BPP_DLY_W{1'b0}};
      qualified_o <= 1'b0;
    end else if (!cond_i) begin
      count_reg <= {`BPP_DLY_W{1'b0}};
      qualified_o <= 1'b0;
    end else if (count_reg >= delay_i) begin
      qualified_o <= 1'b1;
    end else if (tick_i) begin
      count_reg <= count_reg + {{(`BPP_DLY_W-1){1'b0}}, 1'b1};
    end
  end

endmodule

//--- include/bpp_defines.vh
// Shared constants for the battery pack protection control block
`ifndef BPP_DEFINES_VH
`define BPP_DEFINES_VH

// ****************************************
// Clock and timing
// ****************************************
`define BPP_CLK_HZ 10000000
// Undervoltage shutdown wait, seconds
`define BPP_UV_SHDN_S 8
`define BPP_UV_SHDN_CYC (`BPP_UV_SHDN_S * `BPP_CLK_HZ)
// Tick of the delay counters: 20 us per tick
`define BPP_TICK_US 20
`define BPP_TICK_CYC ((`BPP_TICK_US * `BPP_CLK_HZ) / 1000000)
`define BPP_DLY_W 24

// ****************************************
// Discharge overcurrent threshold codes
// ****************************************
`define BPP_OCD_LO_MIN_MV 25
`define BPP_OCD_LO_STEP_MV 5
`define BPP_OCD_HI_MIN_MV 125
`define BPP_OCD_HI_STEP_MV 25
`define BPP_OCD_CODE_MAX 4'hF

// ****************************************
// Fault vector bit positions
// ****************************************
`define BPP_F_OV 0
`define BPP_F_UV 1
`define BPP_F_OCD 2
`define BPP_F_SCD 3
`define BPP_F_SCC 4
`define BPP_NF 5

`endif

//--- test/bpp_ctrl_props.sv
// Port checker for the battery pack protection control block
`timescale 1ns/1ps
`include "bpp_defines.vh"
// ****************************************
// Port-level checks
// ****************************************
module bpp_ctrl_chk (
  // Clock and reset
  input wire clock_i,
  input wire sys_rst_i,
  // Observed inputs
  input wire charger_sense_pin_i,
  input wire pack_negative_sense_pin_i,
  input wire ocd_i,
  input wire hw_fault_i,
  input wire ocd_range_high_i,
  input wire [3:0] ocd_code_i,
  input wire short_overcurrent_recovery_select_i,
  // Observed outputs
  input wire charge_fet_enable_o,
  input wire discharge_fet_enable_o,
  input wire regulator_enable_o,
  input wire shutdown_o,
  input wire charger_present_o,
  input wire load_removed_o,
  input wire [8:0] ocd_threshold_mv_o,
  input wire [`BPP_NF-1:0] fault_latched_o
);
  wire fets_off = !charge_fet_enable_o && !discharge_fet_enable_o;
  wire [8:0] code9 = {5'h00, ocd_code_i};
  // Expected threshold, worked out apart from the design
  wire [8:0] thr_exp = ocd_range_high_i ? 9'h07D + 9'h019 * code9 : 9'h019 + 9'h005 * code9;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  a_shdn_reg_off: assert property (shutdown_o |-> !regulator_enable_o)
    else $error("regulator on in shutdown");
  a_shdn_fets_off: assert property (shutdown_o |-> fets_off)
    else $error("fets on in shutdown");
  a_active_reg_on: assert property (!shutdown_o && !$past(shutdown_o) && !$past(sys_rst_i)
    |-> regulator_enable_o)
    else $error("regulator off while active");
  a_chg_detect: assert property (!shutdown_o && !$past(sys_rst_i)
    |-> charger_present_o == $past(charger_sense_pin_i))
    else $error("charger flag wrong");
  a_load_flag: assert property ($rose(load_removed_o) |-> $past(pack_negative_sense_pin_i))
    else $error("load removal without comparator");
  // Sampled reset in the antecedent: the release edge still loads the reset value
  a_ocd_thr_map: assert property (!sys_rst_i && !shutdown_o
    |=> ocd_threshold_mv_o == $past(thr_exp))
    else $error("threshold mapping wrong");
  a_trip_fets: assert property ($rose(|fault_latched_o[4:2]) |-> ##[0:2] fets_off)
    else $error("fets not off after trip");
  a_trip_cause: assert property ($rose(fault_latched_o[`BPP_F_OCD])
    |-> $past(ocd_i, 2) || $past(ocd_i, 3))
    else $error("overcurrent trip without cause");
  a_sor_charger: assert property ($fell(fault_latched_o[`BPP_F_SCD]) &&
    short_overcurrent_recovery_select_i |-> charger_present_o || $past(charger_present_o))
    else $error("short recovery without charger");
  a_clear_fets_on: assert property ((fault_latched_o == 5'h00 && !hw_fault_i && !shutdown_o)[*4]
    |-> charge_fet_enable_o && discharge_fet_enable_o)
    else $error("fets off with no fault");
  // Main scenarios reached
  c_ocd: cover property ($rose(fault_latched_o[`BPP_F_OCD]));
  c_scd: cover property ($rose(fault_latched_o[`BPP_F_SCD]));
  c_load: cover property ($rose(load_removed_o));
endmodule
bind bpp_ctrl bpp_ctrl_chk chk_u (.clock_i, .sys_rst_i, .charger_sense_pin_i,
  .pack_negative_sense_pin_i, .ocd_i, .hw_fault_i, .ocd_range_high_i, .ocd_code_i,
  .short_overcurrent_recovery_select_i, .charge_fet_enable_o, .discharge_fet_enable_o,
  .regulator_enable_o, .shutdown_o, .charger_present_o, .load_removed_o,
  .ocd_threshold_mv_o, .fault_latched_o);

//--- test/bpp_ctrl_test.sv
// Self-checking testbench for the protection control block
`timescale 1ns/1ps
`include "bpp_defines.vh"
module bpp_ctrl_test;
  reg clock_i = 1'b0, sys_rst_i = 1'b1, chg_on = 1'b0, load_on = 1'b1;
  reg ov = 1'b0, uv = 1'b0, discharge_overcurrent = 1'b0, discharge_short_circuit = 1'b0, charge_short_circuit = 1'b0, rng = 1'b0, short_overcurrent_recovery_select = 1'b0;
  reg [3:0] code = 4'h0;
  reg hwf = 1'b0, uvrs = 1'b0;
  reg [23:0] scc_dly = 24'h00000A;
  wire cs, pn, c_en, d_en, reg_en, shdn;
  wire [8:0] thr;
  integer n_errors = 0, n_checks = 0, r, k;
  always #50 clock_i = ~clock_i;
  bpp_pack_model pack_u (.clock_i(clock_i), .discharge_fet_enable_i(d_en),
    .charger_on_i(chg_on), .load_on_i(load_on), .charger_sense_pin_o(cs),
    .pack_negative_sense_pin_o(pn));
  bpp_ctrl dut_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .charger_sense_pin_i(cs),
    .pack_negative_sense_pin_i(pn), .cell_ov_i(ov), .cell_ov_rel_i(ov), .cell_uv_i(uv),
    .cell_uv_hyst_i(uv), .ocd_i(discharge_overcurrent), .scd_i(discharge_short_circuit), .scc_i(charge_short_circuit), .hw_fault_i(hwf),
    .ov_delay_i(24'h000000), .uv_delay_i(24'h000000), .ocd_delay_i(24'h000000),
    .scd_delay_i(24'h000000), .scc_delay_i(scc_dly), .ocd_range_high_i(rng),
    .ocd_code_i(code), .short_overcurrent_recovery_select_i(short_overcurrent_recovery_select),
    .uv_recovery_select_i(uvrs), .undervoltage_shutdown_enable_i(1'b1),
    .charge_fet_enable_o(c_en), .discharge_fet_enable_o(d_en), .regulator_enable_o(reg_en),
    .shutdown_o(shdn), .charger_present_o(), .load_removed_o(), .ocd_threshold_mv_o(thr),
    .fault_latched_o());
  // ****************************************
  // Tasks
  // ****************************************
  task cyc(input integer n);
    repeat (n) @(posedge clock_i);
  endtask
  // Compare at once; callers step to a falling edge first, where outputs have settled
  task chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task final_report;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Bounded wait for a FET pair; a timeout ends the run
  task wait_fets(input logic c, input logic d, input integer lim);
    integer i;
    @(negedge clock_i);
    for (i = 0; i < lim && {c_en, d_en} !== {c, d}; i++) @(negedge clock_i);
    chk("fets", {7'h00, c, d}, {7'h00, c_en, d_en});
    if ({c_en, d_en} !== {c, d}) final_report();
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    cyc(5);
    sys_rst_i <= 1'b0;
    cyc(3);
    @(negedge clock_i);
    chk("mode", 9'h002, {7'h00, reg_en, shdn});
    wait_fets(1'b1, 1'b1, 5);
    for (r = 0; r < 32; r++) begin
      cyc(1);
      {rng, code} <= r[4:0];
      cyc(3);
      @(negedge clock_i);
      chk("thr", r[4] ? 125 + 25 * r[3:0] : 25 + 5 * r[3:0], thr);
    end
    cyc(1);
    discharge_overcurrent <= 1'b1;
    wait_fets(1'b0, 1'b0, 1000);
    cyc(1);
    discharge_overcurrent <= 1'b0;
    cyc(500);
    @(negedge clock_i);
    chk("dsg", 9'h000, {8'h00, d_en});
    cyc(1);
    load_on <= 1'b0;
    wait_fets(1'b1, 1'b1, 50);
    cyc(1);
    {load_on, short_overcurrent_recovery_select, discharge_short_circuit} <= 3'b111;
    wait_fets(1'b0, 1'b0, 1000);
    cyc(1);
    {load_on, discharge_short_circuit} <= 2'b00;
    cyc(500);
    @(negedge clock_i);
    chk("dsg", 9'h000, {8'h00, d_en});
    cyc(1);
    chg_on <= 1'b1;
    wait_fets(1'b1, 1'b1, 50);
    cyc(1);
    {chg_on, load_on, ov} <= 3'b011;
    wait_fets(1'b0, 1'b1, 1000);
    cyc(1);
    {ov, uv, uvrs} <= 3'b011;
    wait_fets(1'b1, 1'b0, 1000);
    cyc(1);
    uv <= 1'b0;
    // With UV recovery select set, cells alone must not release discharge
    cyc(50);
    @(negedge clock_i);
    chk("dsg", 9'h000, {8'h00, d_en});
    cyc(1);
    load_on <= 1'b0;
    wait_fets(1'b1, 1'b1, 50);
    cyc(1);
    {load_on, hwf} <= 2'b11;
    wait_fets(1'b0, 1'b0, 5);
    cyc(1);
    hwf <= 1'b0;
    wait_fets(1'b1, 1'b1, 5);
    // Short pulses must never trip: the count restarts each time
    for (k = 0; k < 3; k++) begin
      cyc(1);
      charge_short_circuit <= 1'b1;
      cyc(1000);
      charge_short_circuit <= 1'b0;
      @(negedge clock_i);
      chk("chg", 9'h001, {8'h00, c_en});
    end
    cyc(1);
    charge_short_circuit <= 1'b1;
    wait_fets(1'b0, 1'b0, 3000);
    cyc(1);
    {sys_rst_i, charge_short_circuit} <= 2'b10;
    cyc(5);
    sys_rst_i <= 1'b0;
    cyc(3);
    wait_fets(1'b1, 1'b1, 5);
    final_report();
  end
endmodule

//--- test/bpp_pack_model.sv
// Model of the pack side: discharge FET, charger and load seen by the comparators
`timescale 1ns/1ps
module bpp_pack_model (
  // Clock
  input wire clock_i,
  // FET drive and pack state
  input wire discharge_fet_enable_i,
  input wire charger_on_i,
  input wire load_on_i,
  // Comparator outputs
  output reg charger_sense_pin_o,
  output reg pack_negative_sense_pin_o
);
  // Comparators settle one cycle late, like the real pins
  always @(posedge clock_i) begin
    charger_sense_pin_o <= charger_on_i;
    pack_negative_sense_pin_o <= !discharge_fet_enable_i && !load_on_i;
  end
endmodule
